/* include/dor_pkg.sv */
// package for the digital output router: bus carriers, register map, field layout and timing constants
package dor_pkg;

  // apb request and answer carriers
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } dor_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dor_apb_rsp_t;

  // byte addresses of the registers
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_CFG_UNUSED  = 12'h004;
  localparam logic [11:0] ADDR_INVERT      = 12'h008;
  localparam logic [11:0] ADDR_FORCE_EN    = 12'h00C;
  localparam logic [11:0] ADDR_FORCE_VAL   = 12'h010;
  localparam logic [11:0] ADDR_APPLIED     = 12'h014;
  localparam logic [11:0] ADDR_ROUTING_EN  = 12'h018;
  localparam logic [11:0] ADDR_LED_EN      = 12'h01C;
  localparam logic [11:0] ADDR_PIN_READ    = 12'h020;
  localparam logic [11:0] ADDR_ROUTE_BASE  = 12'h040;
  localparam int          ROUTE_SHIFT      = 2;

  // reset values and the routing enable value
  localparam logic [31:0] RST_WORD         = 32'h0000_0000;
  localparam logic [15:0] ROUTE_OFF        = 16'h0FFF;
  localparam logic [31:0] ROUTING_ON_VALUE = 32'h0000_0001;

  // field layout
  localparam int          OUT_BASE_BIT     = 16;
  localparam int          BRAKE_BIT        = 0;
  localparam int          LED_GREEN_BIT    = 0;
  localparam int          LED_RED_BIT      = 1;
  localparam int          GATE_INV_BIT     = 7;
  localparam int          LOW_WORD_BITS    = 16;

  // routing source codes (high byte of a routing entry)
  localparam logic [7:0]  SRC_ONE          = 8'h00;
  localparam logic [7:0]  SRC_ZERO         = 8'h01;
  localparam logic [7:0]  SRC_ENC_FIRST    = 8'h02;
  localparam logic [7:0]  SRC_ENC_LAST     = 8'h08;
  localparam logic [7:0]  SRC_POS_FIRST    = 8'h09;
  localparam logic [7:0]  SRC_POS_LAST     = 8'h0F;
  localparam logic [7:0]  SRC_PWM          = 8'h10;
  localparam logic [7:0]  SRC_PWM_INV      = 8'h11;

  // timing
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          SOFT_PWM_MAX_HZ  = 2000;
  localparam int          OUT_MAX_HZ       = 500;
  localparam int          LED_FLASH_HALF_MS = 500;
  // shortest half period a channel may show, rounded up
  localparam int          SOFT_HOLD_CYC_DEF = (CLK_HZ + 2 * SOFT_PWM_MAX_HZ - 1) / (2 * SOFT_PWM_MAX_HZ);
  localparam int          OUT_HOLD_CYC_DEF  = (CLK_HZ + 2 * OUT_MAX_HZ - 1) / (2 * OUT_MAX_HZ);
  localparam int          LED_HALF_CYC_DEF  = (CLK_HZ / 1000) * LED_FLASH_HALF_MS;

endpackage

/* src/dor_output_router.sv */
// digital output router: control word, inversion, forcing, routing, apb register file and open-drain pins

// What this block does
// - output n follows control word bit 15+n: output 1 is bit 16
// - low sixteen control bits are special functions; bit 0 drives the brake
// - each config register bit acts only on the output at that bit position
// - invert bit clear: one drives high; invert bit set: one drives low
// - force enable takes the pin value from the force value, brake included
// - force value bits are ignored where force enable is clear
// - applied value register shows the final pin levels after every stage
// - led bit 0 enables flashing green, bit 1 red on error; clear keeps off
// - routing enable equal to one puts all outputs in routing mode
// - routing entry: 16 bits, high byte source, low byte gating bit
// - entry 1 is the soft pwm output, entry 2 output 1, and upward
// - gating bit one switches on; entry bit 7 set makes zero switch on
// - entry value FFF disables routing for that output
// - source 00 is constant one, source 01 constant zero
// - sources 02 to 08 give encoder pulses divided by 1 to 64
// - sources 09 to 0F give position pulses divided by 1 to 64
// - divider 1 gives one pulse per single change of the count
// - source 10 routes the brake pwm, source 11 the inverted brake pwm
// - soft pwm output may reach 2 kHz, every other output only 500 Hz
// - pins are open drain: pull low or release, high needs a pull-up
// - with automatic brake control off, control bit 0 commands the brake
module dor_output_router
  import dor_pkg::*;
#(
  parameter int NUM_OUT       = 2,
  parameter int SOFT_HOLD_CYC = dor_pkg::SOFT_HOLD_CYC_DEF,
  parameter int OUT_HOLD_CYC  = dor_pkg::OUT_HOLD_CYC_DEF,
  parameter int LED_HALF_CYC  = dor_pkg::LED_HALF_CYC_DEF
)
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // register bus
  input  wire dor_pkg::dor_apb_req_t apb_req,
  output dor_pkg::dor_apb_rsp_t      apb_rsp,
  // motion sources
  input  wire logic [31:0]           encoder_count,
  input  wire logic [31:0]           position_actual,
  input  wire logic                  brake_pwm,
  input  wire logic                  auto_brake_enable,
  input  wire logic                  auto_brake_cmd,
  input  wire logic                  drive_error,
  // open-drain output pins
  input  wire logic [NUM_OUT-1:0]    out_pin_in,
  output logic      [NUM_OUT-1:0]    out_pin_out,
  output logic      [NUM_OUT-1:0]    out_pin_oe,
  // open-drain brake pin
  input  wire logic                  brake_pin_in,
  output logic                       brake_pin_out,
  output logic                       brake_pin_oe,
  // open-drain soft pwm pin
  input  wire logic                  soft_pwm_pin_in,
  output logic                       soft_pwm_pin_out,
  output logic                       soft_pwm_pin_oe,
  // power leds
  output logic                       led_green,
  output logic                       led_red
);

  import dor_pkg::*;

  localparam int NCH     = NUM_OUT + 1;
  localparam int HOLD_MX = (SOFT_HOLD_CYC > OUT_HOLD_CYC) ? SOFT_HOLD_CYC : OUT_HOLD_CYC;
  localparam int HOLD_W  = $clog2(HOLD_MX + 1);
  localparam int FLASH_W = $clog2(LED_HALF_CYC + 1);
  localparam logic [HOLD_W-1:0]  SOFT_HOLD_LAST = HOLD_W'(SOFT_HOLD_CYC - 1);
  localparam logic [HOLD_W-1:0]  OUT_HOLD_LAST  = HOLD_W'(OUT_HOLD_CYC - 1);
  localparam logic [FLASH_W-1:0] FLASH_LAST     = FLASH_W'(LED_HALF_CYC - 1);

  // refuse sizes that the bit layout or counters cannot serve
  if (NUM_OUT < 1 || NUM_OUT > 16)
  begin : g_bad_num_out
    $error("NUM_OUT must lie between 1 and 16");
  end
  if (SOFT_HOLD_CYC < 1 || OUT_HOLD_CYC < 1 || LED_HALF_CYC < 1)
  begin : g_bad_counts
    $error("hold and flash counts must be at least one");
  end

  // whole state of the block
  typedef struct packed {
    logic [31:0]                  ctrl;
    logic [31:0]                  invert;
    logic [31:0]                  force_en;
    logic [31:0]                  force_val;
    logic [31:0]                  routing_en;
    logic [31:0]                  led_en;
    logic [NCH-1:0][15:0]         route;
    logic [NCH-1:0][5:0]          div_cnt;
    logic [NCH-1:0][HOLD_W-1:0]   hold;
    logic [NCH-1:0]               lvl;
    logic [31:0]                  applied;
    logic                         soft_pwm;
    logic [31:0]                  enc_prev;
    logic [31:0]                  pos_prev;
    logic [FLASH_W-1:0]           flash_cnt;
    logic                         flash;
    logic [1:0]                   led;
    logic [31:0]                  prdata;
  } dor_state_t;

  dor_state_t st;
  dor_state_t next_st;

  // merge write data into a register under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return res;
  endfunction

  // decode a routing entry address: valid flag and channel index
  function automatic logic [5:0] route_sel(input logic [11:0] addr);
    logic [11:0] off;
    logic [11:0] idx;
    off = addr - ADDR_ROUTE_BASE;
    idx = off >> ROUTE_SHIFT;
    if (addr >= ADDR_ROUTE_BASE && off[1:0] == 2'b00 && idx < 12'(NCH))
    begin
      return {1'b1, idx[4:0]};
    end
    return 6'h00;
  endfunction

  // decode any mapped address
  function automatic logic addr_hit(input logic [11:0] addr);
    logic [5:0] rs;
    rs = route_sel(addr);
    return rs[5] || addr == ADDR_CTRL || addr == ADDR_CFG_UNUSED || addr == ADDR_INVERT ||
           addr == ADDR_FORCE_EN || addr == ADDR_FORCE_VAL || addr == ADDR_APPLIED ||
           addr == ADDR_ROUTING_EN || addr == ADDR_LED_EN || addr == ADDR_PIN_READ;
  endfunction

  // gating term: selected low-word bit, optionally inverted
  function automatic logic gate_on(input logic [15:0] low_word, input logic [15:0] entry);
    logic [6:0] idx;
    logic       sel;
    idx = entry[6:0];
    sel = (idx < 7'(LOW_WORD_BITS)) ? low_word[idx[3:0]] : 1'b0;
    return sel ^ entry[GATE_INV_BIT];
  endfunction

  // one stage chain for a pin: direct or routed, then inversion, then forcing
  function automatic logic resolve(input logic pre, input logic inv, input logic fen, input logic fval);
    logic lv;
    lv = pre ^ inv;
    return fen ? fval : lv;
  endfunction

  // apb answer: zero wait states, data registered in the setup cycle
  always_comb
  begin
    apb_rsp.pready  = apb_req.psel & apb_req.penable;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_hit(apb_req.paddr);
    apb_rsp.prdata  = st.prdata;
  end

  // next-state logic
  always_comb
  begin
    logic        enc_evt;
    logic        pos_evt;
    logic        routing_mode;
    logic        evt;
    logic        pulse;
    logic        src;
    logic        raw;
    logic [7:0]  code;
    logic [2:0]  k;
    logic [5:0]  last;
    logic [5:0]  rs;
    logic        wr;
    logic        pre;
    logic        brake_pre;
    logic [HOLD_W-1:0] hold_last;
    logic [31:0] rd;
    enc_evt      = 1'b0;
    pos_evt      = 1'b0;
    routing_mode = 1'b0;
    evt          = 1'b0;
    pulse        = 1'b0;
    src          = 1'b0;
    raw          = 1'b0;
    code         = 8'h00;
    k            = 3'h0;
    last         = 6'h00;
    rs           = 6'h00;
    wr           = 1'b0;
    pre          = 1'b0;
    brake_pre    = 1'b0;
    hold_last    = '0;
    rd           = 32'h0000_0000;
    next_st      = st;

    // any change of a count is one increment event; larger jumps count once
    enc_evt = encoder_count != st.enc_prev;
    pos_evt = position_actual != st.pos_prev;
    next_st.enc_prev = encoder_count;
    next_st.pos_prev = position_actual;
    routing_mode = st.routing_en == ROUTING_ON_VALUE;

    // led flash timebase and enables
    if (st.flash_cnt == FLASH_LAST)
    begin
      next_st.flash_cnt = '0;
      next_st.flash     = ~st.flash;
    end
    else
    begin
      next_st.flash_cnt = st.flash_cnt + FLASH_W'(1);
    end
    next_st.led[LED_GREEN_BIT] = st.led_en[LED_GREEN_BIT] & st.flash;
    next_st.led[LED_RED_BIT]   = st.led_en[LED_RED_BIT] & drive_error & st.flash;

    // per channel: source, divider, gating and rate limit
    for (int ch = 0; ch < NCH; ch++)
    begin
      code  = st.route[ch][15:8];
      evt   = 1'b0;
      k     = 3'h0;
      pulse = 1'b0;
      if (code >= SRC_ENC_FIRST && code <= SRC_ENC_LAST)
      begin
        evt = enc_evt;
        k   = 3'(code - SRC_ENC_FIRST);
      end
      else if (code >= SRC_POS_FIRST && code <= SRC_POS_LAST)
      begin
        evt = pos_evt;
        k   = 3'(code - SRC_POS_FIRST);
      end
      last = 6'((7'h01 << k) - 7'h01);
      if (evt)
      begin
        if (st.div_cnt[ch] == last)
        begin
          next_st.div_cnt[ch] = 6'h00;
          pulse = 1'b1;
        end
        else
        begin
          next_st.div_cnt[ch] = st.div_cnt[ch] + 6'h01;
        end
      end
      if (code == SRC_ONE)
      begin
        src = 1'b1;
      end
      else if (code == SRC_ZERO)
      begin
        src = 1'b0;
      end
      else if (code == SRC_PWM)
      begin
        src = brake_pwm;
      end
      else if (code == SRC_PWM_INV)
      begin
        src = ~brake_pwm;
      end
      else
      begin
        src = pulse;
      end
      raw = src & gate_on(st.ctrl[15:0], st.route[ch]);
      // a level may only change once per half period of the channel's top rate
      hold_last = (ch == 0) ? SOFT_HOLD_LAST : OUT_HOLD_LAST;
      if (st.hold[ch] != '0)
      begin
        next_st.hold[ch] = st.hold[ch] - HOLD_W'(1);
      end
      else if (raw != st.lvl[ch])
      begin
        next_st.lvl[ch]  = raw;
        next_st.hold[ch] = hold_last;
      end
    end

    // brake pin: direct bit 0 unless automatic control owns it
    brake_pre = auto_brake_enable ? auto_brake_cmd : st.ctrl[BRAKE_BIT];
    next_st.applied = 32'h0000_0000;
    next_st.applied[BRAKE_BIT] = resolve(brake_pre, st.invert[BRAKE_BIT],
                                         st.force_en[BRAKE_BIT], st.force_val[BRAKE_BIT]);
    for (int n = 0; n < NUM_OUT; n++)
    begin
      pre = st.ctrl[OUT_BASE_BIT + n];
      if (routing_mode && st.route[n + 1] != ROUTE_OFF)
      begin
        pre = st.lvl[n + 1];
      end
      next_st.applied[OUT_BASE_BIT + n] = resolve(pre, st.invert[OUT_BASE_BIT + n],
                                                  st.force_en[OUT_BASE_BIT + n],
                                                  st.force_val[OUT_BASE_BIT + n]);
    end
    // soft pwm pin only carries a signal while its entry routes one
    next_st.soft_pwm = routing_mode && st.route[0] != ROUTE_OFF && st.lvl[0];

    // register writes take effect in the access cycle
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rs = route_sel(apb_req.paddr);
    if (wr)
    begin
      if (apb_req.paddr == ADDR_CTRL)
      begin
        next_st.ctrl = merge_strb(st.ctrl, apb_req.pwdata, apb_req.pstrb);
      end
      if (apb_req.paddr == ADDR_INVERT)
      begin
        next_st.invert = merge_strb(st.invert, apb_req.pwdata, apb_req.pstrb);
      end
      if (apb_req.paddr == ADDR_FORCE_EN)
      begin
        next_st.force_en = merge_strb(st.force_en, apb_req.pwdata, apb_req.pstrb);
      end
      if (apb_req.paddr == ADDR_FORCE_VAL)
      begin
        next_st.force_val = merge_strb(st.force_val, apb_req.pwdata, apb_req.pstrb);
      end
      if (apb_req.paddr == ADDR_ROUTING_EN)
      begin
        next_st.routing_en = merge_strb(st.routing_en, apb_req.pwdata, apb_req.pstrb);
      end
      if (apb_req.paddr == ADDR_LED_EN)
      begin
        next_st.led_en = merge_strb(st.led_en, apb_req.pwdata, apb_req.pstrb);
      end
      if (rs[5])
      begin
        next_st.route[rs[4:0]]   = 16'(merge_strb({16'h0000, st.route[rs[4:0]]}, apb_req.pwdata, apb_req.pstrb));
        next_st.div_cnt[rs[4:0]] = 6'h00;
      end
    end

    // read data captured in the setup cycle, stable through the access phase
    if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite)
    begin
      if (apb_req.paddr == ADDR_CTRL)
      begin
        rd = st.ctrl;
      end
      if (apb_req.paddr == ADDR_INVERT)
      begin
        rd = st.invert;
      end
      if (apb_req.paddr == ADDR_FORCE_EN)
      begin
        rd = st.force_en;
      end
      if (apb_req.paddr == ADDR_FORCE_VAL)
      begin
        rd = st.force_val;
      end
      if (apb_req.paddr == ADDR_APPLIED)
      begin
        rd = st.applied;
      end
      if (apb_req.paddr == ADDR_ROUTING_EN)
      begin
        rd = st.routing_en;
      end
      if (apb_req.paddr == ADDR_LED_EN)
      begin
        rd = st.led_en;
      end
      if (apb_req.paddr == ADDR_PIN_READ)
      begin
        rd[BRAKE_BIT] = brake_pin_in;
        rd[OUT_BASE_BIT +: NUM_OUT] = out_pin_in;
        rd[BRAKE_BIT + 1] = soft_pwm_pin_in;
      end
      if (rs[5])
      begin
        rd = {16'h0000, st.route[rs[4:0]]};
      end
      next_st.prdata = rd;
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st            <= '0;
      st.ctrl       <= RST_WORD;
      st.invert     <= RST_WORD;
      st.force_en   <= RST_WORD;
      st.force_val  <= RST_WORD;
      st.routing_en <= RST_WORD;
      st.led_en     <= RST_WORD;
      st.route      <= {NCH{ROUTE_OFF}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // open drain: pull low for a zero, release for a one
  always_comb
  begin
    out_pin_out      = '0;
    out_pin_oe       = ~st.applied[OUT_BASE_BIT +: NUM_OUT];
    brake_pin_out    = 1'b0;
    brake_pin_oe     = ~st.applied[BRAKE_BIT];
    soft_pwm_pin_out = 1'b0;
    soft_pwm_pin_oe  = ~st.soft_pwm;
    led_green        = st.led[LED_GREEN_BIT];
    led_red          = st.led[LED_RED_BIT];
  end

endmodule

/* dv/dor_output_router_checker.sv */
// assertion checker for the digital output router ports
module dor_output_router_checker
  import dor_pkg::*;
#(
  parameter int NUM_OUT = 2
)
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  srst,
  // register bus
  input wire dor_pkg::dor_apb_req_t apb_req,
  input wire dor_pkg::dor_apb_rsp_t apb_rsp,
  // status input
  input wire logic                  drive_error,
  // pins and leds
  input wire logic [NUM_OUT-1:0]    out_pin_out,
  input wire logic [NUM_OUT-1:0]    out_pin_oe,
  input wire logic                  brake_pin_out,
  input wire logic                  brake_pin_oe,
  input wire logic                  soft_pwm_pin_out,
  input wire logic                  soft_pwm_pin_oe,
  input wire logic                  led_green,
  input wire logic                  led_red
);
  logic access;
  logic mapped;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // decode mirrors the map; only aligned offsets are driven, so holes are simple
  always_comb
  begin
    access = apb_req.psel && apb_req.penable;
    mapped = (apb_req.paddr[1:0] == 2'b00) && ((apb_req.paddr <= ADDR_PIN_READ) ||
             ((apb_req.paddr >= ADDR_ROUTE_BASE) && (apb_req.paddr <= ADDR_ROUTE_BASE + 12'(4 * NUM_OUT))));
  end

  // bus phases
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_read;
    apb_req.psel && apb_req.penable && !apb_req.pwrite;
  endsequence

  AST_OPEN_DRAIN: assert property ((out_pin_out == '0) && !brake_pin_out && !soft_pwm_pin_out)
    else $error("output pin driven high");
  AST_READY: assert property (apb_rsp.pready == access)
    else $error("pready does not follow the access phase");
  AST_HOLE_ERR: assert property (access && !mapped |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  AST_NO_ERR: assert property (!(access && !mapped) |-> !apb_rsp.pslverr)
    else $error("error on a mapped access");
  AST_HOLE_DATA: assert property (s_read ##0 apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("refused read returns data");
  // two reset edges, though the first edge already clears the soft pwm level register and every other pin and led
  AST_RESET_PINS: assert property (disable iff (1'b0) srst [*2] |=>
    (&out_pin_oe) && brake_pin_oe && soft_pwm_pin_oe && !led_green && !led_red)
    else $error("pins or leds not idle in reset");
  AST_RED_CAUSE: assert property (led_red |-> $past(drive_error))
    else $error("red led lit without error");
  // read data is captured at the setup edge, so it matches the pins of the setup cycle
  AST_APPLIED_READ: assert property (s_setup ##1 (s_read ##0 apb_req.paddr == ADDR_APPLIED) |->
    apb_rsp.prdata[OUT_BASE_BIT +: NUM_OUT] == ~$past(out_pin_oe) &&
    apb_rsp.prdata[BRAKE_BIT] == !$past(brake_pin_oe))
    else $error("applied value differs from pins");
  AST_CFG_ZERO: assert property (s_read ##0 apb_req.paddr == ADDR_CFG_UNUSED |-> apb_rsp.prdata == '0)
    else $error("unused config reads nonzero");
endmodule

bind dor_output_router dor_output_router_checker #(.NUM_OUT(NUM_OUT)) u_dor_output_router_checker (
  .ref_clk(ref_clk),
  .srst(srst),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .drive_error(drive_error),
  .out_pin_out(out_pin_out),
  .out_pin_oe(out_pin_oe),
  .brake_pin_out(brake_pin_out),
  .brake_pin_oe(brake_pin_oe),
  .soft_pwm_pin_out(soft_pwm_pin_out),
  .soft_pwm_pin_oe(soft_pwm_pin_oe),
  .led_green(led_green),
  .led_red(led_red)
);

/* dv/dor_load_model.sv */
// pull-up loads on the open-drain output, brake and soft pwm pins
module dor_load_model #(
  parameter int NUM_OUT = 2
)
(
  // device side
  input wire logic [NUM_OUT-1:0] out_pin_out,
  input wire logic [NUM_OUT-1:0] out_pin_oe,
  input wire logic               brake_pin_out,
  input wire logic               brake_pin_oe,
  input wire logic               soft_pwm_pin_out,
  input wire logic               soft_pwm_pin_oe,
  // wire levels
  output logic [NUM_OUT-1:0]     out_lvl,
  output logic                   brake_lvl,
  output logic                   soft_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin goes high through its resistor, never keeps a stale value
  assign out_lvl   = ~out_pin_oe | out_pin_out;
  assign brake_lvl = ~brake_pin_oe | brake_pin_out;
  assign soft_lvl  = ~soft_pwm_pin_oe | soft_pwm_pin_out;
endmodule

/* dv/tb_top.sv */
// self-checking bench for the digital output router
module tb_top;
  import dor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NOUT = 2;
  logic            ref_clk, srst, brake_pwm, auto_brake_enable, auto_brake_cmd, drive_error;
  dor_apb_req_t    req;
  dor_apb_rsp_t    rsp;
  logic [31:0]     encoder_count, position_actual, rd;
  logic [NOUT-1:0] out_lvl, out_pin_out, out_pin_oe;
  logic            brake_lvl, brake_pin_out, brake_pin_oe, soft_lvl, soft_pwm_pin_out, soft_pwm_pin_oe;
  logic            led_green, led_red, er;
  int              error_cnt, n_tests, cyc;

  dor_output_router #(.NUM_OUT(NOUT), .SOFT_HOLD_CYC(4), .OUT_HOLD_CYC(4), .LED_HALF_CYC(8)) u_dor_output_router (
    .ref_clk(ref_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
    .encoder_count(encoder_count), .position_actual(position_actual), .brake_pwm(brake_pwm),
    .auto_brake_enable(auto_brake_enable), .auto_brake_cmd(auto_brake_cmd), .drive_error(drive_error),
    .out_pin_in(out_lvl), .out_pin_out(out_pin_out), .out_pin_oe(out_pin_oe),
    .brake_pin_in(brake_lvl), .brake_pin_out(brake_pin_out), .brake_pin_oe(brake_pin_oe),
    .soft_pwm_pin_in(soft_lvl), .soft_pwm_pin_out(soft_pwm_pin_out), .soft_pwm_pin_oe(soft_pwm_pin_oe),
    .led_green(led_green), .led_red(led_red));

  dor_load_model #(.NUM_OUT(NOUT)) u_dor_load_model (
    .out_pin_out(out_pin_out), .out_pin_oe(out_pin_oe), .brake_pin_out(brake_pin_out),
    .brake_pin_oe(brake_pin_oe), .soft_pwm_pin_out(soft_pwm_pin_out), .soft_pwm_pin_oe(soft_pwm_pin_oe),
    .out_lvl(out_lvl), .brake_lvl(brake_lvl), .soft_lvl(soft_lvl));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard; the whole run needs well under half of this
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      $display("FAIL t=%0t timeout", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: 4'hF};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // wait for register, level and pin stages to land, sample mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    chk(32'({brake_pin_oe, soft_pwm_pin_oe, out_pin_oe}), 32'h0000_000F);
    rdchk(ADDR_CTRL, RST_WORD);
    rdchk(ADDR_ROUTE_BASE + 12'h004, 32'(ROUTE_OFF));
    xfer(1'b0, 12'h100, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    wr(ADDR_APPLIED, 32'hFFFF_FFFF);
    wr(ADDR_CFG_UNUSED, 32'hFFFF_FFFF);
    rdchk(ADDR_APPLIED, 32'h0000_0000);
    rdchk(ADDR_CFG_UNUSED, 32'h0000_0000);
  endtask

  task automatic t_direct();
    wr(ADDR_CTRL, 32'h0002_0001);
    settle(4);
    chk(32'({brake_pin_oe, out_pin_oe}), 32'h0000_0001);
    rdchk(ADDR_APPLIED, 32'h0002_0001);
    rdchk(ADDR_PIN_READ, 32'h0002_0001);
    {auto_brake_enable, auto_brake_cmd} <= 2'b10;
    settle(4);
    chk(32'(brake_pin_oe), 32'h0000_0001);
    @(posedge ref_clk);
    auto_brake_enable <= 1'b0;
    wr(ADDR_INVERT, 32'h0001_0000);
    settle(4);
    chk(32'(out_pin_oe), 32'h0000_0000);
    rdchk(ADDR_APPLIED, 32'h0003_0001);
  endtask

  task automatic t_force();
    wr(ADDR_FORCE_EN, 32'h0002_0001);
    wr(ADDR_FORCE_VAL, 32'h0000_0000);
    settle(4);
    rdchk(ADDR_APPLIED, 32'h0001_0000);
    wr(ADDR_FORCE_VAL, 32'h0002_0001);
    settle(4);
    rdchk(ADDR_APPLIED, 32'h0003_0001);
    wr(ADDR_FORCE_EN, 32'h0000_0000);
    wr(ADDR_INVERT, 32'h0000_0000);
  endtask

  task automatic t_route();
    logic [15:0] ent [9] = '{16'h0005, 16'h0085, 16'h0105, 16'h0004, 16'h0084, 16'h1005, 16'h1105, 16'h0FFF,
                             16'h0105};
    logic        on [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(ADDR_CTRL, 32'h0001_0020);
    brake_pwm <= 1'b1;
    wr(ADDR_ROUTING_EN, ROUTING_ON_VALUE);
    for (int i = 0; i < 9; i++)
    begin
      wr(ADDR_ROUTE_BASE + 12'h004, 32'(ent[i]));
      settle(10);
      chk(32'(out_pin_oe[0]), 32'(!on[i]));
    end
    wr(ADDR_ROUTE_BASE, 32'h0000_0005);
    settle(10);
    chk(32'(soft_pwm_pin_oe), 32'h0000_0000);
    wr(ADDR_ROUTING_EN, 32'h0000_0002);
    settle(10);
    chk(32'(out_pin_oe[0]), 32'h0000_0000);
    wr(ADDR_ROUTING_EN, ROUTING_ON_VALUE);
  endtask

  // each code: no pulse until the last of div increments, then one pulse
  task automatic t_pulse();
    int div;
    int hits;
    for (int c = 2; c <= 15; c++)
    begin
      div = 1 << ((c - 2) % 7);
      wr(ADDR_ROUTE_BASE + 12'h004, {16'h0000, 8'(c), 8'h05});
      settle(10);
      for (int k = 1; k <= div; k++)
      begin
        @(posedge ref_clk);
        if (c >= 9)
          position_actual <= position_actual + 32'h0000_0001;
        else
          encoder_count <= encoder_count + 32'h0000_0001;
        hits = 0;
        repeat (12)
        begin
          @(negedge ref_clk);
          if (out_pin_oe[0] === 1'b0)
            hits++;
        end
        chk(32'(hits > 0), 32'(k == div));
      end
    end
  endtask

  task automatic t_led();
    int g;
    int r;
    for (int m = 3; m >= 0; m--)
    begin
      wr(ADDR_LED_EN, 32'(m));
      drive_error <= (m != 2);
      settle(4);
      g = 0;
      r = 0;
      repeat (40)
      begin
        @(negedge ref_clk);
        g += int'(led_green === 1'b1);
        r += int'(led_red === 1'b1);
      end
      chk(32'(g > 0 && g < 40), 32'(m % 2 == 1));
      chk(32'(r > 0 && r < 40), 32'(m == 3));
    end
  endtask

  initial
  begin
    req = '0;
    encoder_count = '0;
    position_actual = '0;
    {brake_pwm, auto_brake_enable, auto_brake_cmd, drive_error} = 4'h0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    srst = 1'b1;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    drive_error <= 1'b1;
    settle(1);
    t_reset();
    t_direct();
    t_force();
    t_route();
    t_pulse();
    t_led();
    final_report();
  end
endmodule
